// >>> rtl/bus_master_access_guard_consts.svh
// Constants for the bus master access guard
`ifndef BUS_MASTER_ACCESS_GUARD_CONSTS_SVH
`define BUS_MASTER_ACCESS_GUARD_CONSTS_SVH
`define GUARD_ADDR_W 16
`define GUARD_DATA_W 32
`define GUARD_IDX_W 7
`define GUARD_MASTER_W 4
`define GUARD_NUM_APB 7'h3A
`define GUARD_NUM 7'h45
`define GUARD_NUM_INT 69
`define GUARD_PERM_RESET 32'h0000_0000
`define GUARD_BUS1_DELTA 16'h1000
`define GUARD_IDX_TWO_WIRE_A_FIRST 7'h1A
`define GUARD_IDX_TWO_WIRE_A_SECOND 7'h36
`define GUARD_IDX_RAM_BANK_A 7'h3E
// Offsets by guard index, index 0 first; 58 peripheral-bus then 11 system
`define GUARD_OFFSET_TABLE { \
	16'h0000, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0030, \
	16'h0034, 16'h0038, 16'h0040, 16'h0044, 16'h0048, 16'h0050, \
	16'h0060, 16'h0064, 16'h0068, 16'h006C, 16'h0080, 16'h0090, \
	16'h0100, 16'h0110, 16'h0120, 16'h0130, 16'h0140, 16'h0150, \
	16'h01B0, 16'h01C0, 16'h01D0, 16'h01E0, 16'h01F0, 16'h0260, \
	16'h0270, 16'h0280, 16'h0290, 16'h0294, 16'h02A0, 16'h02A4, \
	16'h02F0, 16'h0330, 16'h0340, 16'h0350, 16'h0360, 16'h0370, \
	16'h03A0, 16'h03C0, 16'h03D0, 16'h03E0, 16'h0420, 16'h0430, \
	16'h0440, 16'h0460, 16'h0470, 16'h04C0, 16'h04D0, 16'h0500, \
	16'h11D0, 16'h11E0, 16'h11F0, 16'h13C0, \
	16'h0B10, 16'h0B60, 16'h0BC0, 16'h0BE0, 16'h0F00, 16'h0F10, \
	16'h0F20, 16'h0F30, 16'h0F40, 16'h0F50, 16'h0F60 }
`endif

// >>> rtl/bus_master_access_guard_pkg.sv
// Types shared by the bus master access guard
package bus_master_access_guard_pkg;
	typedef logic [31:0] perm_t;
	typedef struct packed {
		logic hit;
		logic [6:0] idx;
	} decode_s;
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_DONE = 1'b1
	} apb_state_e;
endpackage

// >>> rtl/bus_master_access_guard.sv
// Permission register bank and access checker for bus masters
//
// Notes on behaviour
// RULE_01: Each peripheral-bus guard register is a 32-bit read/write field, reset zero.
// RULE_02: Peripheral guard bit 0 for a master lets it read and write.
// RULE_03: Peripheral guard bit 1 for a master refuses both reads and writes.
// RULE_04: System guard register is 32-bit, reset zero, one write/read pair per master.
// RULE_05: System pair 00 permits both writes and reads.
// RULE_06: System pair 01 permits writes, blocks reads.
// RULE_07: System pair 10 blocks writes, permits reads.
// RULE_08: System pair 11 blocks writes and reads.
// RULE_09: Software leaves bits of absent masters at their reset value.
// RULE_10: One peripheral guard register per peripheral, offsets 0x0000 to 0x13C0.
// RULE_11: System guard registers decoded at offsets 0x0B10 through 0x0F60.
// RULE_12: Dual-mapped two-wire units get a second copy 0x1000 above the first.
// RULE_13: A refused access answers the master with a bus error.
// RULE_14: All guards clear at power-on and on the software guard reset.
// RULE_15: Bit position, or bit pair, is tied to one fixed master number.
// RULE_16: A refused access leaves the slave untouched and returns no data.
`timescale 1ns/1ns
`include "bus_master_access_guard_consts.svh"

module bus_master_access_guard (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Guard reset from the global reset register
	input wire logic swGuardReset,
	// Register port, peripheral bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`GUARD_ADDR_W-1:0] paddr,
	input wire logic [`GUARD_DATA_W-1:0] pwdata,
	output logic [`GUARD_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Access check request from a master
	input wire logic chkValid,
	input wire logic [`GUARD_MASTER_W-1:0] chkMaster,
	input wire logic chkWrite,
	input wire logic [`GUARD_IDX_W-1:0] chkSlave,
	input wire logic [`GUARD_DATA_W-1:0] slvRdata,
	// Access check answer
	output logic chkDone,
	output logic chkFault,
	output logic slvEnable,
	output logic [`GUARD_DATA_W-1:0] mstRdata
);

////////////////////////////////////////////////////////////////////////////
	localparam logic [16*`GUARD_NUM_INT-1:0] OFFSETS = `GUARD_OFFSET_TABLE;

	bus_master_access_guard_pkg::perm_t perm_q [`GUARD_NUM_INT];
	bus_master_access_guard_pkg::apb_state_e state_q;
	logic [`GUARD_DATA_W-1:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic chkDone_q;
	logic chkFault_q;
	logic slvEnable_q;
	logic [`GUARD_DATA_W-1:0] mstRdata_q;
	bus_master_access_guard_pkg::decode_s dec;
	logic apbTake;
	logic chkKnown;
	logic chkDeny;
	bus_master_access_guard_pkg::perm_t chkPerm;

////////////////////////////////////////////////////////////////////////////
	// Offset of a guard index; the table lists index 0 in its top bits
	function automatic logic [15:0] offsetOf(input logic [6:0] i);
		logic [6:0] rev;
		rev = 7'(`GUARD_NUM - 7'h01 - i);
		return OFFSETS[16*rev +: 16];
	endfunction

	// Lowest index wins when two entries share one offset
	function automatic bus_master_access_guard_pkg::decode_s
		decodeAddr(input logic [15:0] a);
		bus_master_access_guard_pkg::decode_s r;
		r = '0;
		for (int i = `GUARD_NUM_INT - 1; i >= 0; i--)
		begin
			if (offsetOf(7'(i)) == a)
			begin
				r.hit = 1'b1;
				r.idx = 7'(i);
			end
		end
		return r;
	endfunction

	// Deny decision for one master against one guard word
	function automatic logic denyOf(
		input bus_master_access_guard_pkg::perm_t p,
		input logic isSys,
		input logic [3:0] m,
		input logic wr
	);
		logic [4:0] pairBase;
		pairBase = {m, 1'b0};
		if (!isSys)
			return p[{1'b0, m}]; // [RULE_02] [RULE_03] [RULE_15]
		else if (wr)
			return p[pairBase + 5'h01]; // [RULE_06] [RULE_07] [RULE_15]
		else
			return p[pairBase]; // [RULE_05] [RULE_08] [RULE_06] [RULE_07]
	endfunction

////////////////////////////////////////////////////////////////////////////
	// Register port decode
	assign dec = decodeAddr(paddr); // [RULE_10] [RULE_11] [RULE_12]
	assign apbTake = psel && penable &&
		(state_q == bus_master_access_guard_pkg::ST_IDLE);

	// Two-cycle answer: ready rises one cycle after the access phase opens
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			state_q <= bus_master_access_guard_pkg::ST_IDLE;
		else
		begin
			case (state_q)
				bus_master_access_guard_pkg::ST_IDLE:
				begin
					if (psel && penable)
						state_q <= bus_master_access_guard_pkg::ST_DONE;
				end
				bus_master_access_guard_pkg::ST_DONE:
					state_q <= bus_master_access_guard_pkg::ST_IDLE;
				default:
					state_q <= bus_master_access_guard_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= `GUARD_PERM_RESET;
		end
		else
		begin
			pready_q <= apbTake;
			pslverr_q <= apbTake && !dec.hit;
			if (apbTake && !pwrite && dec.hit)
				prdata_q <= perm_q[dec.idx];
			else
				prdata_q <= `GUARD_PERM_RESET;
		end
	end

	// Guard words; the software reset overrides a write in the same cycle
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < `GUARD_NUM_INT; i++)
				perm_q[i] <= `GUARD_PERM_RESET; // [RULE_01] [RULE_04]
		end
		else if (swGuardReset)
		begin
			for (int i = 0; i < `GUARD_NUM_INT; i++)
				perm_q[i] <= `GUARD_PERM_RESET; // [RULE_14]
		end
		else if (apbTake && pwrite && dec.hit)
			perm_q[dec.idx] <= pwdata; // [RULE_01] [RULE_04]
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

////////////////////////////////////////////////////////////////////////////
	// Access check: answer one cycle after the request, every request
	// An index outside the bank is refused rather than let through
	assign chkKnown = chkSlave < `GUARD_NUM;
	assign chkPerm = chkKnown ? perm_q[chkSlave] : `GUARD_PERM_RESET;
	assign chkDeny = !chkKnown ||
		denyOf(chkPerm, chkSlave >= `GUARD_NUM_APB, chkMaster, chkWrite);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			chkDone_q <= 1'b0;
			chkFault_q <= 1'b0;
			slvEnable_q <= 1'b0;
		end
		else
		begin
			chkDone_q <= chkValid;
			chkFault_q <= chkValid && chkDeny; // [RULE_13]
			slvEnable_q <= chkValid && !chkDeny; // [RULE_16]
		end
	end

	// Read data is forced to zero unless a read was granted
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			mstRdata_q <= `GUARD_PERM_RESET;
		else if (chkValid && !chkWrite && !chkDeny)
			mstRdata_q <= slvRdata;
		else
			mstRdata_q <= `GUARD_PERM_RESET; // [RULE_16]
	end

	assign chkDone = chkDone_q;
	assign chkFault = chkFault_q;
	assign slvEnable = slvEnable_q;
	assign mstRdata = mstRdata_q;

////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	logic [4:0] chkPair;
	logic chkIsSys;
	assign chkPair = {chkMaster, 1'b0};
	assign chkIsSys = chkKnown && (chkSlave >= `GUARD_NUM_APB);

	property p_apb_allow;
		chkValid && chkKnown && !chkIsSys && !chkPerm[{1'b0, chkMaster}]
		|=> chkDone && !chkFault && slvEnable;
	endproperty
	a_apb_allow: assert property (p_apb_allow) // [RULE_02]
		else $error("peripheral access with clear bit was refused");

	property p_apb_deny;
		chkValid && chkKnown && !chkIsSys && chkPerm[{1'b0, chkMaster}]
		|=> chkFault && !slvEnable;
	endproperty
	a_apb_deny: assert property (p_apb_deny) // [RULE_03]
		else $error("peripheral access with set bit was let through");

	property p_sys_both_ok;
		chkValid && chkIsSys &&
		chkPerm[chkPair +: 2] == 2'h0
		|=> !chkFault ##0 slvEnable;
	endproperty
	a_sys_both_ok: assert property (p_sys_both_ok) // [RULE_05]
		else $error("system pair 00 refused an access");

	property p_sys_read_block;
		chkValid && chkIsSys && !chkWrite &&
		chkPerm[chkPair +: 2] == 2'h1
		|=> chkFault;
	endproperty
	a_sys_read_block: assert property (p_sys_read_block) // [RULE_06]
		else $error("system pair 01 let a read through");

	property p_sys_write_block;
		chkValid && chkIsSys && chkWrite &&
		chkPerm[chkPair +: 2] == 2'h2
		|=> chkFault;
	endproperty
	a_sys_write_block: assert property (p_sys_write_block) // [RULE_07]
		else $error("system pair 10 let a write through");

	property p_sys_all_block;
		chkValid && chkIsSys && chkPerm[chkPair +: 2] == 2'h3
		|=> chkFault && !slvEnable;
	endproperty
	a_sys_all_block: assert property (p_sys_all_block) // [RULE_08]
		else $error("system pair 11 let an access through");

	property p_fault_no_data;
		chkFault |-> mstRdata == `GUARD_PERM_RESET && !slvEnable;
	endproperty
	a_fault_no_data: assert property (p_fault_no_data) // [RULE_16]
		else $error("refused access reached the slave or returned data");

	property p_fault_is_done;
		chkFault |-> chkDone && $past(chkValid);
	endproperty
	a_fault_is_done: assert property (p_fault_is_done) // [RULE_13]
		else $error("fault without a request the cycle before");

	property p_unmapped;
		apbTake && !dec.hit |=> pready && pslverr &&
		prdata == `GUARD_PERM_RESET ##1 !pready;
	endproperty
	a_unmapped: assert property (p_unmapped) // [RULE_10]
		else $error("unmapped offset did not answer with an error");

	property p_write_store;
		apbTake && pwrite && dec.hit && !swGuardReset &&
		dec.idx == `GUARD_IDX_RAM_BANK_A
		|=> perm_q[`GUARD_IDX_RAM_BANK_A] == $past(pwdata) && !pslverr;
	endproperty
	a_write_store: assert property (p_write_store) // [RULE_11]
		else $error("system guard write was not stored");

	property p_second_copy;
		apbTake && pwrite && !swGuardReset &&
		paddr == offsetOf(`GUARD_IDX_TWO_WIRE_A_FIRST) + `GUARD_BUS1_DELTA
		|=> perm_q[`GUARD_IDX_TWO_WIRE_A_SECOND] == $past(pwdata) &&
		$stable(perm_q[`GUARD_IDX_TWO_WIRE_A_FIRST]);
	endproperty
	a_second_copy: assert property (p_second_copy) // [RULE_12]
		else $error("second bus copy not kept apart from the first");

	property p_sw_reset;
		swGuardReset |=> perm_q[0] == `GUARD_PERM_RESET &&
		perm_q[`GUARD_NUM_INT-1] == `GUARD_PERM_RESET;
	endproperty
	a_sw_reset: assert property (p_sw_reset) // [RULE_14]
		else $error("software guard reset left a word set");

	property p_read_back;
		apbTake && !pwrite && dec.hit && dec.idx == 7'h00 &&
		!swGuardReset
		|=> prdata == perm_q[0] && pready;
	endproperty
	a_read_back: assert property (p_read_back) // [RULE_01]
		else $error("register read did not return the stored word");

	property p_sys_write_ok;
		chkValid && chkIsSys && chkWrite &&
		chkPerm[chkPair +: 2] == 2'h1
		|=> slvEnable && !chkFault;
	endproperty
	a_sys_write_ok: assert property (p_sys_write_ok) // [RULE_06]
		else $error("system pair 01 refused a write");

	property p_sys_read_ok;
		chkValid && chkIsSys && !chkWrite &&
		chkPerm[chkPair +: 2] == 2'h2
		|=> slvEnable && !chkFault;
	endproperty
	a_sys_read_ok: assert property (p_sys_read_ok) // [RULE_07]
		else $error("system pair 10 refused a read");

	// An index past the bank must never reach a slave
	property p_unknown_slave;
		chkValid && !chkKnown |=> chkFault && !slvEnable;
	endproperty
	a_unknown_slave: assert property (p_unknown_slave) // [RULE_13]
		else $error("request to an unknown slave was not refused");

	property p_read_pass;
		chkValid && !chkWrite && !chkDeny
		|=> mstRdata == $past(slvRdata);
	endproperty
	a_read_pass: assert property (p_read_pass) // [RULE_02]
		else $error("granted read did not return the slave data");

	property p_done_every;
		chkValid |=> chkDone;
	endproperty
	a_done_every: assert property (p_done_every) // [RULE_13]
		else $error("request left without an answer");

	property p_idle_quiet;
		!chkValid |=> !chkDone && !slvEnable &&
		mstRdata == `GUARD_PERM_RESET;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) // [RULE_16]
		else $error("answer or slave access without a request");

	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) // [RULE_10]
		else $error("ready stood for more than one cycle");

	// Read data stays zero outside the answer so no word leaks out
	property p_data_only_answer;
		!pready |-> prdata == `GUARD_PERM_RESET;
	endproperty
	a_data_only_answer: assert property (p_data_only_answer) // [RULE_10]
		else $error("register data shown outside an answer cycle");

	c_apb_write: cover property (apbTake && pwrite && dec.hit ##1 pready);
	c_apb_fault: cover property (chkValid && !chkIsSys ##1 chkFault);
	c_sys_read_ok: cover property (chkValid && chkIsSys && !chkWrite
		##1 slvEnable);
	c_sw_reset: cover property (swGuardReset);
	c_second_copy: cover property (apbTake && pwrite && dec.hit &&
		dec.idx == `GUARD_IDX_TWO_WIRE_A_SECOND);

endmodule

// >>> testbench/far_slave_model.sv
// Slave side model: read data that moves every cycle, count of grants
`timescale 1ns/1ns

module far_slave_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Guard answer
	input wire logic slvEnable,
	// Slave view
	output logic [31:0] slvRdata,
	output int grants
);

////////////////////////////////////////////////////////////////////////////
// Data changes each cycle so a stale or wrong sample edge shows up
always_ff @(posedge ref_clk or posedge rst)
begin
	if (rst)
		slvRdata <= 32'h1357_9BDF;
	else
		slvRdata <= {slvRdata[30:0], ~slvRdata[31]};
end

////////////////////////////////////////////////////////////////////////////
// Only a granted access may touch the slave
always_ff @(posedge ref_clk or posedge rst)
begin
	if (rst)
		grants <= 0;
	else if (slvEnable)
		grants <= grants + 1;
end

endmodule

// >>> testbench/bus_master_access_guard_tb.sv
// Self-checking bench for the bus master access guard
`timescale 1ns/1ns
`include "bus_master_access_guard_consts.svh"

module bus_master_access_guard_tb;

logic ref_clk = 1'b0;
logic rst = 1'b1;
logic swGuardReset = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [15:0] paddr = 16'h0000;
logic [31:0] pwdata = 32'h0000_0000;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic chkValid = 1'b0;
logic chkWrite = 1'b0;
logic [3:0] chkMaster = 4'h0;
logic [6:0] chkSlave = 7'h00;
logic [31:0] slvRdata;
logic [31:0] mstRdata;
logic chkDone;
logic chkFault;
logic slvEnable;
int grants;
int n_fail = 0;
int checked = 0;
logic [1103:0] offTab = `GUARD_OFFSET_TABLE;

always #5 ref_clk = ~ref_clk;

bus_master_access_guard dut_u (.ref_clk(ref_clk), .rst(rst),
	.swGuardReset(swGuardReset), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .chkValid(chkValid),
	.chkMaster(chkMaster), .chkWrite(chkWrite), .chkSlave(chkSlave),
	.slvRdata(slvRdata), .chkDone(chkDone), .chkFault(chkFault),
	.slvEnable(slvEnable), .mstRdata(mstRdata));

far_slave_model slave_u (.ref_clk(ref_clk), .rst(rst),
	.slvEnable(slvEnable), .slvRdata(slvRdata), .grants(grants));

////////////////////////////////////////////////////////////////////////////
function automatic logic [15:0] off(input int i);
	return offTab[(68 - i) * 16 +: 16];
endfunction

// Kept to bits 0..9 so absent masters stay at reset value
function automatic logic [31:0] val(input int i);
	return {25'h0, i[6:0]} ^ 32'h0000_0280;
endfunction

task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
	checked++;
	if (got !== exp)
	begin
		n_fail++;
		$display("ERROR %s expected %h seen %h", what, exp, got);
	end
endtask

task apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
	input logic [31:0] exp, input logic expErr);
	@(posedge ref_clk);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= wr;
	paddr <= a;
	pwdata <= d;
	@(posedge ref_clk);
	penable <= 1'b1;
	@(posedge ref_clk);
	#1;
	cmp("pready", 32'h1, {31'h0, pready});
	cmp("pslverr", {31'h0, expErr}, {31'h0, pslverr});
	cmp("prdata", wr ? 32'h0 : exp, prdata);
	@(posedge ref_clk);
	psel <= 1'b0;
	penable <= 1'b0;
endtask

task chk(input logic [3:0] m, input logic wr, input logic [6:0] s,
	input logic expFault);
	logic [31:0] d;
	int g;
	g = grants;
	@(posedge ref_clk);
	chkValid <= 1'b1;
	chkMaster <= m;
	chkWrite <= wr;
	chkSlave <= s;
	#1;
	d = slvRdata;
	@(posedge ref_clk);
	chkValid <= 1'b0;
	#1;
	cmp("chkDone", 32'h1, {31'h0, chkDone});
	cmp("chkFault", {31'h0, expFault}, {31'h0, chkFault});
	cmp("slvEnable", {31'h0, !expFault}, {31'h0, slvEnable});
	cmp("mstRdata", (expFault || wr) ? 32'h0 : d, mstRdata);
	@(posedge ref_clk);
	#1;
	cmp("grants", g + (expFault ? 0 : 1), grants);
endtask

task results;
	$display("checked %0d n_fail %0d", checked, n_fail);
	if (n_fail == 0 && checked > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask

////////////////////////////////////////////////////////////////////////////
initial
begin
	#300000;
	n_fail++;
	results;
end

initial
begin
	repeat (8) @(posedge ref_clk);
	rst <= 1'b0;
	for (int i = 0; i < 69; i++)
		apb(1'b0, off(i), 32'h0, 32'h0, 1'b0);
	for (int i = 0; i < 69; i++)
		apb(1'b1, off(i), val(i), 32'h0, 1'b0);
	for (int i = 0; i < 69; i++)
		apb(1'b0, off(i), 32'h0, val(i), 1'b0);
	apb(1'b1, 16'h0FFC, 32'hFFFF_FFFF, 32'h0, 1'b1);
	apb(1'b0, 16'h0FFC, 32'h0, 32'h0, 1'b1);
	for (int m = 0; m < 10; m++)
	begin
		apb(1'b1, 16'h0030, 32'h1 << m, 32'h0, 1'b0);
		chk(m[3:0], 1'b0, 7'h05, 1'b1);
		chk(m[3:0], 1'b1, 7'h05, 1'b1);
		chk(m[3:0] ^ 4'h1, 1'b0, 7'h05, 1'b0);
		chk(m[3:0] ^ 4'h1, 1'b1, 7'h05, 1'b0);
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, 16'h0F00, c << (2 * m), 32'h0, 1'b0);
			chk(m[3:0], 1'b1, 7'h3E, c[1]);
			chk(m[3:0], 1'b0, 7'h3E, c[0]);
		end
	end
	apb(1'b1, 16'h01D0, 32'h1, 32'h0, 1'b0);
	apb(1'b1, 16'h11D0, 32'h0, 32'h0, 1'b0);
	chk(4'h0, 1'b0, 7'h1A, 1'b1);
	chk(4'h0, 1'b0, 7'h36, 1'b0);
	chk(4'h0, 1'b0, 7'h45, 1'b1);
	@(posedge ref_clk);
	swGuardReset <= 1'b1;
	@(posedge ref_clk);
	swGuardReset <= 1'b0;
	apb(1'b0, 16'h0F00, 32'h0, 32'h0, 1'b0);
	apb(1'b0, 16'h01D0, 32'h0, 32'h0, 1'b0);
	chk(4'h9, 1'b1, 7'h05, 1'b0);
	results;
end

endmodule
